//--- fcp_pkg.sv
// Package with constants, states and carrier types for the flash pin controller.
package fcp_pkg;
   // ==========================================================
   // Timing and widths.
   localparam int CLK_PERIOD_NS = 20;
   localparam int STROBE_NS = 60;
   localparam int SETUP_NS = 40;
   localparam int RESET_NS = 500;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [15:0] DATA_ZERO = 16'h0000;
   localparam logic [19:0] ADDR_ZERO = 20'h0_0000;

   // ==========================================================
   // Protect pin drive modes.
   typedef enum logic [1:0] {
      PROT_LOCK,
      PROT_NORMAL,
      PROT_ACCEL
   } fcp_prot_type;

   // Controller states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_RESET
   } fcp_state_type;

   // One write request from the user side.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic byteMode;
      logic lastCycle;
   } fcp_req_type;

   // Control pins toward the flash, all low-active except word select.
   typedef struct packed {
      logic chipSel_n;
      logic outStrobe_n;
      logic writeStrobe_n;
      logic wordSel;
      logic reset_n;
   } fcp_pins_type;
endpackage

//--- fcp_flash_host.sv
// Host-side controller that drives the flash control pins for write cycles.
`timescale 1ns/10ps
module fcp_flash_host #(
   parameter int ADDR_W = fcp_pkg::ADDR_W,
   parameter int DATA_W = fcp_pkg::DATA_W
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // User request side.
   input wire logic reqValid,
   input wire fcp_pkg::fcp_req_type reqInfo,
   input wire logic resetReq,
   input wire fcp_pkg::fcp_prot_type protMode,
   output logic reqReady,
   output logic opDone,
   output logic devBusy,
   // Flash pins.
   output fcp_pkg::fcp_pins_type flashPins,
   output logic [ADDR_W-1:0] flashAddr,
   output logic [DATA_W-1:0] flashDataOut,
   output logic flashDataOe,
   output logic protectLow,
   output logic high_program_voltage,
   input wire logic op_done_status
);
   // ==========================================================
   // Cycle plan of one write, counted from the edge that takes the request:
   //   edge 0      request taken; address, data, width select and sequence end latched;
   //   edge 0      chip select low and data bus driven on the same edge, output strobe stays high;
   //   setup       the write strobe stays high for the setup count;
   //   strobe      the write strobe is low for the strobe count;
   //   hold        one cycle with chip select still low after the strobe rises;
   //   idle        chip select high, the request side is offered again.
   // The strobe rises one cycle before chip select, so the flash latches the cycle on the strobe edge
   // with chip select still low. Fixed counts were chosen over programmable ones because the
   // controller serves one device speed; a faster part only wastes a few cycles per write.
   // A reset request takes the place of a write and holds the reset pin low for the reset count.
   // ==========================================================
   // Parameter check.
   // The request and pin carriers are packed with the package widths, so other widths cannot be served.
   if (ADDR_W != fcp_pkg::ADDR_W || DATA_W != fcp_pkg::DATA_W) begin : gBad
      $error("fcp_flash_host: widths must match the package");
   end
   // Each phase needs at least one cycle, and its load value must fit the shared down-counter.
   if (fcp_pkg::SETUP_CYC < 1 || fcp_pkg::SETUP_CYC > (1 << fcp_pkg::CNT_W)) begin : gBadSetup
      $error("fcp_flash_host: setup count does not fit the counter");
   end
   if (fcp_pkg::STROBE_CYC < 1 || fcp_pkg::STROBE_CYC > (1 << fcp_pkg::CNT_W)) begin : gBadStrobe
      $error("fcp_flash_host: strobe count does not fit the counter");
   end
   if (fcp_pkg::RESET_CYC < 1 || fcp_pkg::RESET_CYC > (1 << fcp_pkg::CNT_W)) begin : gBadReset
      $error("fcp_flash_host: reset count does not fit the counter");
   end

   fcp_pkg::fcp_state_type state;
   fcp_pkg::fcp_state_type next_state;
   logic [fcp_pkg::CNT_W-1:0] count;
   logic [fcp_pkg::CNT_W-1:0] next_count;
   logic watchReady;
   // Marks that the request in flight closes a command sequence; held because reqInfo is valid only at take.
   logic lastSeq;

   // ==========================================================
   // Helper functions.
   // True in the phases in which the flash is selected and the host drives the data bus.
   function automatic logic isSelected(input fcp_pkg::fcp_state_type st);
      return (st == fcp_pkg::ST_SETUP) || (st == fcp_pkg::ST_STROBE) || (st == fcp_pkg::ST_HOLD);
   endfunction

   // Load value of the down-counter for a phase that lasts the given number of cycles.
   function automatic logic [fcp_pkg::CNT_W-1:0] loadOf(input int cycles);
      return fcp_pkg::CNT_W'(cycles - 1);
   endfunction

   // ==========================================================
   // Decoding of the state into pin levels and handshake conditions.
   wire logic countDone = (count == fcp_pkg::CNT_ZERO);
   // Requests are taken only in idle, so nothing is lost while a cycle is on the pins.
   wire logic takeReq = (state == fcp_pkg::ST_IDLE) && reqValid && !resetReq;
   // A reset request wins over a write, so a hung flash can always be recovered.
   wire logic startReset = (state == fcp_pkg::ST_IDLE) && resetReq;
   wire logic strobeEnd = (state == fcp_pkg::ST_STROBE) && countDone;
   // Strobe only in the strobe state, with output strobe held high.
   wire logic next_we_n = !(next_state == fcp_pkg::ST_STROBE);
   wire logic next_ce_n = !isSelected(next_state);
   // The data bus is driven exactly while the flash is selected, so it never fights the flash outputs.
   wire logic next_dataOe = isSelected(next_state);
   // The reset pulse on the flash pin lasts for the whole reset state.
   wire logic next_reset_n = !(next_state == fcp_pkg::ST_RESET);
   // A request is offered only in idle and is withdrawn from the cycle after a reset request is seen.
   wire logic next_ready = (next_state == fcp_pkg::ST_IDLE) && !resetReq;
   // The protect pin follows the mode every cycle and is not tied to the sequencer: the user must keep
   // the mode steady across a command sequence and must not leave the high voltage on for other work.
   // Accelerated mode drives the high voltage; lock mode drives the pin low.
   wire logic next_hv = (protMode == fcp_pkg::PROT_ACCEL);
   wire logic next_lock = (protMode == fcp_pkg::PROT_LOCK);

   // ==========================================================
   // Sequencer.
   // Next-state logic for the write and reset sequencer.
   always_comb begin
      next_state = state;
      // The counter runs down to zero and rests there; each phase loads its length less one.
      next_count = countDone ? count : count - fcp_pkg::CNT_ONE;
      case (state)
         // Idle: a reset request is served before a write request.
         fcp_pkg::ST_IDLE: begin
            if (startReset) begin
               next_state = fcp_pkg::ST_RESET;
               next_count = loadOf(fcp_pkg::RESET_CYC);
            end else if (takeReq) begin
               next_state = fcp_pkg::ST_SETUP;
               next_count = loadOf(fcp_pkg::SETUP_CYC);
            end
         end
         // Setup: chip select and data stand before the strobe falls.
         fcp_pkg::ST_SETUP: begin
            if (countDone) begin
               next_state = fcp_pkg::ST_STROBE;
               next_count = loadOf(fcp_pkg::STROBE_CYC);
            end
         end
         // Strobe: the write strobe is low for the whole phase.
         fcp_pkg::ST_STROBE: begin
            if (countDone) begin
               next_state = fcp_pkg::ST_HOLD;
            end
         end
         // Hold: one cycle that keeps address and chip select past the latching edge.
         fcp_pkg::ST_HOLD: begin
            next_state = fcp_pkg::ST_IDLE;
         end
         // Reset: the reset pin stays low until the count runs out.
         fcp_pkg::ST_RESET: begin
            if (countDone) begin
               next_state = fcp_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = fcp_pkg::ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers.
   // State, counter and pin registers.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= fcp_pkg::ST_IDLE;
         count <= fcp_pkg::CNT_ZERO;
         flashPins <= '{chipSel_n: 1'b1, outStrobe_n: 1'b1, writeStrobe_n: 1'b1, wordSel: 1'b1, reset_n: 1'b1};
         reqReady <= 1'b0;
         high_program_voltage <= 1'b0;
         protectLow <= 1'b0;
      end else begin
         // Every pin is registered so the flash sees clean levels with no decode glitches.
         state <= next_state;
         count <= next_count;
         flashPins.chipSel_n <= next_ce_n;
         flashPins.outStrobe_n <= 1'b1; // Never read here, so always high.
         flashPins.writeStrobe_n <= next_we_n; // Rising edge latches the cycle.
         flashPins.reset_n <= next_reset_n;
         // Width select is latched with the request and stands until the next one is taken.
         if (takeReq) begin
            flashPins.wordSel <= !reqInfo.byteMode; // Low selects byte mode.
         end
         reqReady <= next_ready;
         high_program_voltage <= next_hv;
         protectLow <= next_lock;
      end
   end

   // Address and data are held from setup to hold so the latch edge sees them stable.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flashAddr <= fcp_pkg::ADDR_ZERO;
         flashDataOut <= fcp_pkg::DATA_ZERO;
         flashDataOe <= 1'b0;
         lastSeq <= 1'b0;
      end else begin
         if (takeReq) begin
            flashAddr <= reqInfo.addr;
            flashDataOut <= reqInfo.data;
            lastSeq <= reqInfo.lastCycle;
         end
         flashDataOe <= next_dataOe;
      end
   end

   // ==========================================================
   // Completion tracking.
   // Busy is only sampled after the last strobe of a sequence, since earlier it is not valid.
   // The done pulse needs busy to be seen first: a write that the flash refuses, for example into a
   // locked boot sector, never pulls the line low and so never produces a pulse. The watch then
   // stays armed until a later busy period ends or a reset request clears it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         watchReady <= 1'b0;
         devBusy <= 1'b0;
         opDone <= 1'b0;
      end else begin
         opDone <= 1'b0;
         if (state == fcp_pkg::ST_RESET) begin
            watchReady <= 1'b0; // Reset aborts any operation.
            devBusy <= 1'b0;
         end else if (strobeEnd && lastSeq) begin
            watchReady <= 1'b1;
         end else if (watchReady && state == fcp_pkg::ST_IDLE) begin
            devBusy <= !op_done_status; // Low means program or erase active.
            if (op_done_status && devBusy) begin
               watchReady <= 1'b0;
               opDone <= 1'b1;
            end
         end
      end
   end
endmodule

//--- fcp_flash_model.sv
// Behavioural model of the flash device seen through its control pins.
`timescale 1ns/10ps
module fcp_flash_model #(parameter int BUSY_CYC = 20) (
   // Clock for busy timing and pins from the host.
   input wire logic clk_sys,
   input wire fcp_pkg::fcp_pins_type pins,
   input wire logic [19:0] addr,
   input wire logic [15:0] dataIn,
   input wire logic protectLow,
   input wire logic high_program_voltage,
   // Ready/busy line, read as high through its pull-up when released.
   output logic op_done_status
);
   logic [15:0] lastData = 16'h0000;
   logic prevWe = 1'b1;
   int busyCnt = 0;
   // The top boot pair is locked while protect is low, unless high voltage overrides it.
   wire lockHit = protectLow && !high_program_voltage && addr[19:13] == 7'h7F;
   wire weRise = !prevWe && pins.writeStrobe_n && !pins.chipSel_n && pins.outStrobe_n;
   // Unlock cycles at 0x555 start no busy period, so two-cycle programming works.
   always @(posedge clk_sys) begin
      prevWe <= pins.writeStrobe_n;
      if (!pins.reset_n) begin
         busyCnt <= 0;
      end else if (busyCnt > 0) begin
         busyCnt <= busyCnt - 1;
      end else if (weRise && !lockHit) begin
         lastData <= pins.wordSel ? dataIn : {8'h00, dataIn[7:0]};
         busyCnt <= (addr == 20'h0_0555) ? 0 : BUSY_CYC;
      end
   end
   assign op_done_status = (busyCnt == 0);
endmodule

//--- fcp_flash_host_sva.sv
// Checker for the ports of the flash pin controller.
`timescale 1ns/10ps
module fcp_flash_host_chk (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // User side.
   input wire logic reqValid,
   input wire logic resetReq,
   input wire logic reqReady,
   input wire logic opDone,
   input wire logic devBusy,
   input wire fcp_pkg::fcp_req_type reqInfo,
   input wire fcp_pkg::fcp_prot_type protMode,
   // Flash pins.
   input wire fcp_pkg::fcp_pins_type flashPins,
   input wire logic [19:0] flashAddr,
   input wire logic [15:0] flashDataOut,
   input wire logic flashDataOe,
   input wire logic protectLow,
   input wire logic high_program_voltage,
   input wire logic op_done_status
);
   // ==========
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire cs = flashPins.chipSel_n;
   wire we = flashPins.writeStrobe_n;
   wire rn = flashPins.reset_n;
   property p_qual; !we |-> !cs && flashPins.outStrobe_n; endproperty
   a_qual: assert property (p_qual) else $error("bad strobe qualifiers");
   property p_setup; $fell(cs) |-> we[*2] ##1 !we; endproperty
   a_setup: assert property (p_setup) else $error("bad setup");
   property p_strobe; $fell(we) |-> !we[*3] ##1 we ##1 cs; endproperty
   a_strobe: assert property (p_strobe) else $error("bad strobe length");
   property p_stable; !we |-> $stable(flashAddr) && $stable(flashDataOut); endproperty
   a_stable: assert property (p_stable) else $error("bus moved in strobe");
   property p_width; reqValid && reqReady && !resetReq
      |=> flashPins.wordSel == !$past(reqInfo.byteMode) && flashAddr == $past(reqInfo.addr); endproperty
   a_width: assert property (p_width) else $error("bad width or address");
   property p_rst; reqReady && resetReq |=> (!rn && we)[*8]; endproperty
   a_rst: assert property (p_rst) else $error("bad reset pulse");
   property p_prot; high_program_voltage == ($past(protMode) == fcp_pkg::PROT_ACCEL)
      && protectLow == ($past(protMode) == fcp_pkg::PROT_LOCK); endproperty
   a_prot: assert property (p_prot) else $error("bad protect drive");
   property p_done; opDone |-> $past(op_done_status) ##1 !opDone; endproperty
   a_done: assert property (p_done) else $error("bad done pulse");
   property p_oe; flashDataOe == !cs; endproperty
   a_oe: assert property (p_oe) else $error("data drive outside select");
   property p_idle; reqReady |-> cs && rn && we; endproperty
   a_idle: assert property (p_idle) else $error("offered while pins active");
endmodule
bind fcp_flash_host fcp_flash_host_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid),
   .resetReq(resetReq), .reqReady(reqReady), .opDone(opDone), .devBusy(devBusy), .reqInfo(reqInfo),
   .protMode(protMode), .flashPins(flashPins), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
   .flashDataOe(flashDataOe), .protectLow(protectLow), .high_program_voltage(high_program_voltage),
   .op_done_status(op_done_status));

//--- fcp_testbench.sv
// Self-checking testbench for the flash pin controller.
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   logic resetReq = 1'b0;
   fcp_pkg::fcp_req_type reqInfo = '0;
   fcp_pkg::fcp_prot_type protMode = fcp_pkg::PROT_NORMAL;
   logic reqReady, opDone, devBusy, oe, pLow, hv, rdy;
   fcp_pkg::fcp_pins_type pins;
   logic [19:0] fAddr;
   logic [15:0] fData;
   int mismatches = 0;
   int cmp_count = 0;
   always #10 clk_sys = ~clk_sys;
   fcp_flash_host uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid), .reqInfo(reqInfo),
      .resetReq(resetReq), .protMode(protMode), .reqReady(reqReady), .opDone(opDone), .devBusy(devBusy),
      .flashPins(pins), .flashAddr(fAddr), .flashDataOut(fData), .flashDataOe(oe), .protectLow(pLow),
      .high_program_voltage(hv), .op_done_status(rdy));
   fcp_flash_model dev (.clk_sys(clk_sys), .pins(pins), .addr(fAddr), .dataIn(fData), .protectLow(pLow),
      .high_program_voltage(hv), .op_done_status(rdy));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Inputs always move 2 ns after the rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // Bounded wait on reqReady (sel 0) or opDone (sel 1); a hang ends the run.
   task automatic wait_sig(input bit sel);
      for (int i = 0; i < 300; i++) begin
         if ((sel ? opDone : reqReady) === 1'b1) return;
         tick(1);
      end
      mismatches++;
      conclude();
   endtask
   task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic byteM, input logic last);
      wait_sig(0);
      reqValid = 1'b1;
      reqInfo = '{addr: a, data: d, byteMode: byteM, lastCycle: last};
      tick(1);
      reqValid = 1'b0;
   endtask
   task automatic test_word();
      wr(20'h0_1000, 16'hA5C3, 1'b0, 1'b1);
      check("wordSel", pins.wordSel, 1'b1);
      wait_sig(1);
      check("word data", dev.lastData, 16'hA5C3);
      $display("test_word done");
   endtask
   task automatic test_byte();
      wr(20'h0_1001, 16'h5A3C, 1'b1, 1'b1);
      check("wordSel", pins.wordSel, 1'b0);
      wait_sig(1);
      check("byte data", dev.lastData, 16'h003C);
      $display("test_byte done");
   endtask
   task automatic test_reset();
      wr(20'h0_2000, 16'h0F0F, 1'b0, 1'b1);
      tick(12);
      check("busy", devBusy, 1'b1);
      resetReq = 1'b1;
      tick(1);
      resetReq = 1'b0;
      tick(2);
      check("reset pin", pins.reset_n, 1'b0);
      check("ready after reset", rdy, 1'b1);
      check("busy after reset", devBusy, 1'b0);
      $display("test_reset done");
   endtask
   task automatic test_lock();
      protMode = fcp_pkg::PROT_LOCK;
      tick(2);
      check("protect low", pLow, 1'b1);
      wr(20'hF_E000, 16'h1111, 1'b0, 1'b1);
      tick(12);
      check("locked data", dev.lastData, 16'h0F0F);
      $display("test_lock done");
   endtask
   task automatic test_accel();
      protMode = fcp_pkg::PROT_ACCEL;
      tick(2);
      check("high voltage", hv, 1'b1);
      wr(20'h0_0555, 16'h00A0, 1'b0, 1'b0);
      wr(20'hF_E000, 16'h2222, 1'b0, 1'b1);
      wait_sig(1);
      check("accel data", dev.lastData, 16'h2222);
      protMode = fcp_pkg::PROT_NORMAL;
      tick(2);
      check("voltage off", hv, 1'b0);
      $display("test_accel done");
   endtask
   initial begin
      tick(16);
      sys_rst = 1'b0;
      test_word();
      test_byte();
      test_reset();
      test_lock();
      test_accel();
      conclude();
   end
endmodule
